// *** logic/cdid_pkg.sv ***
// Purpose: shared constants and types of the display instruction decoder
// Assumes: 100 MHz system clock, apb register access
// Notes: offsets are byte addresses on the apb side

package cdid_pkg;

  // clock and execution timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CLEAR_TIME_NS = 6200000; // 6.2 ms worst case
  // longest time, so the division rounds down
  localparam int unsigned CLEAR_CYCLES = CLEAR_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned SHORT_CYCLES = 2; // every other instruction
  localparam int CNT_W = 20; // holds CLEAR_CYCLES

  // apb register offsets
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // instruction field positions
  localparam int ENTRY_INC_BIT = 1;
  localparam int ENTRY_SHIFT_BIT = 0;
  localparam int DISP_ON_BIT = 2;
  localparam int CUR_ON_BIT = 1;
  localparam int BLINK_BIT = 0;
  localparam int SHIFT_SC_BIT = 3;
  localparam int SHIFT_RL_BIT = 2;
  localparam int MODE_GC_BIT = 3;
  localparam int MODE_PWR_BIT = 2;
  localparam int FUNC_DL_BIT = 4;
  localparam int FUNC_N_BIT = 3;
  localparam int FUNC_F_BIT = 2;
  localparam logic [1:0] SUB_SHIFT = 2'b00;
  localparam logic [1:0] SUB_MODE = 2'b11;

  // values after reset and fixed codes
  localparam logic RST_INC = 1'b1;
  localparam logic RST_BUS8 = 1'b1;
  localparam logic [1:0] RST_FONT_TABLE = 2'b00;
  localparam logic [1:0] FONT_TABLE_NA = 2'b11;
  localparam logic [7:0] BLANK_CODE = 8'h20;
  localparam int DD_DEPTH = 128;
  localparam int CG_DEPTH = 64;

  // which ram the data register reaches
  typedef enum logic {RAM_DISPLAY, RAM_GLYPH} cdid_ram_sel_t;
  // which half of a byte the next 4-bit transfer carries
  typedef enum logic {NIB_HIGH, NIB_LOW} cdid_nib_t;

endpackage

// *** logic/cdid_ram.sv ***
// Purpose: flip-flop byte memory with whole-array fill
// Assumes: one write port, asynchronous read by index
// Notes: fill wins over a write in the same cycle

`timescale 1ns/1ns

module cdid_ram #(
  parameter int DEPTH = 128,
  parameter int AW = 7,
  parameter logic [7:0] FILL = 8'h20
) (
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic fill_en,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data
);

  logic [7:0] mem_ff [DEPTH]; // byte storage
  logic [7:0] nxt_mem [DEPTH]; // next value of each entry

  // read path is a plain mux; the top registers it before the pins
  assign rd_data = mem_ff[addr];

  // one next-value slice and one register per entry
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_comb begin
      nxt_mem[i] = mem_ff[i];
      if (fill_en) begin
        nxt_mem[i] = FILL; // blanking the whole array
      end else if (wr_en && (addr == AW'(i))) begin
        nxt_mem[i] = wr_data;
      end
    end

    // contents are data, so reset leaves them alone
    always_ff @(posedge sys_clk) begin
      mem_ff[i] <= nxt_mem[i];
    end
  end

endmodule

// *** logic/cdid_top.sv ***
// Purpose: apb-facing instruction decoder of a character display controller
// Assumes: zero-wait apb slave, one access at a time
// Notes: 4-bit mode carries each nibble on pwdata/prdata bits 7:4
//
// Contract
// - two host registers: instruction and data; code also maps a status word at offset 08
// - while busy only status read is honoured
// - busy flag high for whole execution
// - clear blanks display, zeroes address, long busy
// - return home zeroes address and shift
// - entry mode stores direction and auto-shift
// - display control stores display, cursor, blink
// - shift moves cursor or display, RAM untouched
// - mode setting stores graphic and power bits
// - function set stores width, lines, font, table
// - glyph address load selects glyph RAM
// - display address load selects display RAM
// - status read returns busy and address
// - data write stores byte at address
// - data read returns byte at address
// - each data access steps address by one
// - stepped address appears when busy drops
// - auto-shift shifts display with each write; code shifts on display RAM reads too, not on glyph RAM writes
// - 4-bit mode moves bytes as two nibbles
// - font table resets to 00, 11 invalid
// - clear forces increment, keeps auto-shift

`timescale 1ns/1ns

module cdid_top #(
  parameter int unsigned CLEAR_CYC = cdid_pkg::CLEAR_CYCLES,
  parameter int unsigned SHORT_CYC = cdid_pkg::SHORT_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic busy_flag,
  output logic display_on,
  output logic cursor_on,
  output logic blink_on,
  output logic graphic_mode,
  output logic dcdc_on,
  output logic bus_width_select,
  output logic two_line,
  output logic font_tall,
  output logic [1:0] font_table,
  output logic [6:0] display_shift
);

  localparam int CW = cdid_pkg::CNT_W;

  // apb answer registers
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic req_busy_ff, nxt_req_busy; // busy as seen in the setup cycle

  // decoder state
  logic [CW-1:0] cnt_ff, nxt_cnt; // cycles of execution left
  logic busy_ff, nxt_busy; // busy flag seen by the host
  logic [6:0] ac_ff, nxt_ac; // address counter
  logic step_pend_ff, nxt_step_pend; // address step owed at end of busy
  cdid_pkg::cdid_ram_sel_t ram_sel_ff, nxt_ram_sel;
  cdid_pkg::cdid_nib_t nib_ff, nxt_nib;
  logic [3:0] nib_hi_ff, nxt_nib_hi; // first nibble of a write
  logic inc_ff, nxt_inc; // entry direction, 1 = increment
  logic sh_en_ff, nxt_sh_en; // auto-shift on write
  logic disp_ff, nxt_disp;
  logic cur_ff, nxt_cur;
  logic blink_ff, nxt_blink;
  logic gc_ff, nxt_gc;
  logic pwr_ff, nxt_pwr;
  logic bus8_ff, nxt_bus8; // 1 = 8-bit transfers
  logic lines_ff, nxt_lines;
  logic font_ff, nxt_font;
  logic [1:0] ft_ff, nxt_ft;
  logic [6:0] shift_ff, nxt_shift; // display shift offset, +1 = right

  // decode helpers
  logic setup, access_go, hit_instr, hit_data, hit_status;
  logic status_rd, taken, complete;
  logic [7:0] byte_in, byte_rd, dd_rd, cg_rd;
  logic dd_we, cg_we, dd_fill, instr_go, clear_go;

  // pins come straight from registers
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign busy_flag = busy_ff;
  assign display_on = disp_ff;
  assign cursor_on = cur_ff;
  assign blink_on = blink_ff;
  assign graphic_mode = gc_ff;
  assign dcdc_on = pwr_ff;
  assign bus_width_select = bus8_ff;
  assign two_line = lines_ff;
  assign font_tall = font_ff;
  assign font_table = ft_ff;
  assign display_shift = shift_ff;

  // address decode; each register needs an exact match on all eight paddr bits
  assign setup = psel && !penable;
  assign access_go = psel && penable && pready_ff;
  assign hit_instr = (paddr == cdid_pkg::OFS_INSTR);
  assign hit_data = (paddr == cdid_pkg::OFS_DATA);
  assign hit_status = (paddr == cdid_pkg::OFS_STATUS);
  assign status_rd = access_go && hit_instr && !pwrite;
  // busy drops every access except the status read, nibble phase too
  // busy at setup refuses too, so a read answered as refused never steps
  assign taken = access_go && (hit_instr || hit_data) &&
                 ((!busy_ff && !req_busy_ff) || status_rd);
  // a byte is whole on every 8-bit access or on the second nibble
  assign complete = taken && (bus8_ff || nib_ff == cdid_pkg::NIB_LOW);
  assign byte_in = bus8_ff ? pwdata[7:0]
                           : {nib_hi_ff, pwdata[7:4]};
  assign byte_rd = hit_instr ? {busy_ff, ac_ff}
                 : (ram_sel_ff == cdid_pkg::RAM_GLYPH) ? cg_rd
                 : dd_rd;
  assign instr_go = complete && pwrite && hit_instr;
  assign clear_go = instr_go && (byte_in == 8'h01);

  // apb answer: data latched in setup, pready one cycle later
  always_comb begin
    nxt_prdata = prdata_ff;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    nxt_req_busy = req_busy_ff;
    if (setup) begin
      nxt_pready = 1'b1;
      nxt_req_busy = busy_ff; // data was chosen with this busy value
      nxt_prdata = 32'h0000_0000;
      if (!(hit_instr || hit_data || hit_status)) begin
        nxt_pslverr = 1'b1; // unmapped address
      end else if (pwrite) begin
        nxt_prdata = 32'h0000_0000;
      end else if (hit_status) begin
        nxt_prdata = {9'h000, shift_ff, 2'h0, ft_ff, font_ff, lines_ff,
                      bus8_ff, pwr_ff, gc_ff, blink_ff, cur_ff, disp_ff,
                      inc_ff, sh_en_ff, ram_sel_ff, busy_ff};
      end else if (hit_data && busy_ff) begin
        nxt_prdata = 32'h0000_0000; // refused data read reads zero
      end else if (bus8_ff) begin
        nxt_prdata = {24'h00_0000, byte_rd};
      end else if (nib_ff == cdid_pkg::NIB_HIGH) begin
        nxt_prdata = {24'h00_0000, byte_rd[7:4], 4'h0};
      end else begin
        nxt_prdata = {24'h00_0000, byte_rd[3:0], 4'h0};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      req_busy_ff <= 1'b0;
    end else begin
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      req_busy_ff <= nxt_req_busy;
    end
  end

  // instruction execution, data access and busy timing
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_ac = ac_ff;
    nxt_step_pend = step_pend_ff;
    nxt_ram_sel = ram_sel_ff;
    nxt_nib = nib_ff;
    nxt_nib_hi = nib_hi_ff;
    nxt_inc = inc_ff;
    nxt_sh_en = sh_en_ff;
    nxt_disp = disp_ff;
    nxt_cur = cur_ff;
    nxt_blink = blink_ff;
    nxt_gc = gc_ff;
    nxt_pwr = pwr_ff;
    nxt_bus8 = bus8_ff;
    nxt_lines = lines_ff;
    nxt_font = font_ff;
    nxt_ft = ft_ff;
    nxt_shift = shift_ff;
    dd_we = 1'b0;
    cg_we = 1'b0;
    dd_fill = 1'b0;
    // count down; the owed step lands on the edge busy falls
    if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - CW'(1);
      if (cnt_ff == CW'(1) && step_pend_ff) begin
        nxt_ac = inc_ff ? ac_ff + 7'h01 : ac_ff - 7'h01;
        nxt_step_pend = 1'b0;
      end
    end
    // nibble phase: upper half first, then lower
    if (taken && !bus8_ff) begin
      nxt_nib = (nib_ff == cdid_pkg::NIB_HIGH) ? cdid_pkg::NIB_LOW
                                               : cdid_pkg::NIB_HIGH;
      if (pwrite && nib_ff == cdid_pkg::NIB_HIGH) begin
        nxt_nib_hi = pwdata[7:4];
      end
    end else if (bus8_ff) begin
      nxt_nib = cdid_pkg::NIB_HIGH;
    end
    if (complete && hit_data) begin
      // data access: ram write or read, then owe an address step
      nxt_cnt = CW'(SHORT_CYC);
      nxt_step_pend = 1'b1;
      if (pwrite && ram_sel_ff == cdid_pkg::RAM_GLYPH) begin
        cg_we = 1'b1;
      end else if (pwrite) begin
        dd_we = 1'b1;
      end
      // auto-shift rides on display ram writes and reads alike
      if (sh_en_ff && ram_sel_ff == cdid_pkg::RAM_DISPLAY) begin
        // increment direction scrolls left, decrement right
        nxt_shift = inc_ff ? shift_ff - 7'h01
                           : shift_ff + 7'h01;
      end
    end else if (instr_go) begin
      nxt_cnt = CW'(SHORT_CYC);
      casez (byte_in)
        8'b1???????: begin
          nxt_ac = byte_in[6:0];
          nxt_ram_sel = cdid_pkg::RAM_DISPLAY;
        end
        8'b01??????: begin
          nxt_ac = {1'b0, byte_in[5:0]};
          nxt_ram_sel = cdid_pkg::RAM_GLYPH;
        end
        8'b001?????: begin
          nxt_bus8 = byte_in[cdid_pkg::FUNC_DL_BIT];
          nxt_lines = byte_in[cdid_pkg::FUNC_N_BIT];
          nxt_font = byte_in[cdid_pkg::FUNC_F_BIT];
          // the unavailable table code leaves the old table
          if (byte_in[1:0] != cdid_pkg::FONT_TABLE_NA) begin
            nxt_ft = byte_in[1:0];
          end
        end
        8'b0001????: begin
          if (byte_in[1:0] == cdid_pkg::SUB_SHIFT) begin
            if (byte_in[cdid_pkg::SHIFT_SC_BIT]) begin
              nxt_shift = byte_in[cdid_pkg::SHIFT_RL_BIT]
                        ? shift_ff + 7'h01 : shift_ff - 7'h01;
            end else begin
              nxt_ac = byte_in[cdid_pkg::SHIFT_RL_BIT]
                     ? ac_ff + 7'h01 : ac_ff - 7'h01;
            end
          end else if (byte_in[1:0] == cdid_pkg::SUB_MODE) begin
            nxt_gc = byte_in[cdid_pkg::MODE_GC_BIT];
            nxt_pwr = byte_in[cdid_pkg::MODE_PWR_BIT];
          end
        end
        8'b00001???: begin
          nxt_disp = byte_in[cdid_pkg::DISP_ON_BIT];
          nxt_cur = byte_in[cdid_pkg::CUR_ON_BIT];
          nxt_blink = byte_in[cdid_pkg::BLINK_BIT];
        end
        8'b000001??: begin
          nxt_inc = byte_in[cdid_pkg::ENTRY_INC_BIT];
          nxt_sh_en = byte_in[cdid_pkg::ENTRY_SHIFT_BIT];
        end
        8'b0000001?: begin
          // test bit 0 is ignored here
          nxt_ac = 7'h00;
          nxt_shift = 7'h00;
          nxt_ram_sel = cdid_pkg::RAM_DISPLAY;
        end
        8'b00000001: begin
          dd_fill = 1'b1;
          nxt_ac = 7'h00;
          nxt_shift = 7'h00;
          nxt_ram_sel = cdid_pkg::RAM_DISPLAY;
          nxt_inc = 1'b1;
          nxt_step_pend = 1'b0;
          nxt_cnt = CW'(CLEAR_CYC);
        end
        default: begin
          nxt_cnt = CW'(SHORT_CYC); // all-zero code only starts the short busy time
        end
      endcase
    end else if (complete && !pwrite && hit_instr) begin
      nxt_cnt = cnt_ff == '0 ? '0 : nxt_cnt; // status read costs no time
    end
    nxt_busy = (nxt_cnt != '0);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
      ac_ff <= 7'h00;
      step_pend_ff <= 1'b0;
      ram_sel_ff <= cdid_pkg::RAM_DISPLAY;
      nib_ff <= cdid_pkg::NIB_HIGH;
      nib_hi_ff <= 4'h0;
      inc_ff <= cdid_pkg::RST_INC;
      sh_en_ff <= 1'b0;
      disp_ff <= 1'b0;
      cur_ff <= 1'b0;
      blink_ff <= 1'b0;
      gc_ff <= 1'b0;
      pwr_ff <= 1'b0;
      bus8_ff <= cdid_pkg::RST_BUS8;
      lines_ff <= 1'b0;
      font_ff <= 1'b0;
      ft_ff <= cdid_pkg::RST_FONT_TABLE;
      shift_ff <= 7'h00;
    end else begin
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
      ac_ff <= nxt_ac;
      step_pend_ff <= nxt_step_pend;
      ram_sel_ff <= nxt_ram_sel;
      nib_ff <= nxt_nib;
      nib_hi_ff <= nxt_nib_hi;
      inc_ff <= nxt_inc;
      sh_en_ff <= nxt_sh_en;
      disp_ff <= nxt_disp;
      cur_ff <= nxt_cur;
      blink_ff <= nxt_blink;
      gc_ff <= nxt_gc;
      pwr_ff <= nxt_pwr;
      bus8_ff <= nxt_bus8;
      lines_ff <= nxt_lines;
      font_ff <= nxt_font;
      ft_ff <= nxt_ft;
      shift_ff <= nxt_shift;
    end
  end

  // display ram, blanked by the clear instruction
  cdid_ram #(
    .DEPTH(cdid_pkg::DD_DEPTH),
    .AW(7),
    .FILL(cdid_pkg::BLANK_CODE)
  ) u_dd_ram (
    .sys_clk(sys_clk),
    .wr_en(dd_we),
    .fill_en(dd_fill),
    .addr(ac_ff),
    .wr_data(byte_in),
    .rd_data(dd_rd)
  );

  // glyph ram, reached through the low six address bits
  cdid_ram #(
    .DEPTH(cdid_pkg::CG_DEPTH),
    .AW(6),
    .FILL(cdid_pkg::BLANK_CODE)
  ) u_cg_ram (
    .sys_clk(sys_clk),
    .wr_en(cg_we),
    .fill_en(1'b0),
    .addr(ac_ff[5:0]),
    .wr_data(byte_in),
    .rd_data(cg_rd)
  );

  // checks on the decoder
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready_ff ##1 !pready_ff;
  endsequence

  property p_apb_answer;
    @(posedge sys_clk) disable iff (reset) s_setup |=> s_answer;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("apb answer not one cycle after setup");

  property p_busy_blocks;
    @(posedge sys_clk) disable iff (reset)
      (busy_ff && access_go && pwrite) |-> !dd_we && !cg_we && !dd_fill;
  endproperty
  a_busy_blocks: assert property (p_busy_blocks)
    else $error("write acted while busy");

  property p_busy_ends;
    @(posedge sys_clk) disable iff (reset)
      (cnt_ff == CW'(1) && !instr_go) |=> !busy_ff;
  endproperty
  a_busy_ends: assert property (p_busy_ends)
    else $error("busy flag did not drop at end of execution");

  property p_clear;
    @(posedge sys_clk) disable iff (reset)
      clear_go |=> busy_ff && ac_ff == 7'h00 && cnt_ff == CW'(CLEAR_CYC)
                   && inc_ff && $stable(sh_en_ff);
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear display did not load its state");

  property p_status_read;
    @(posedge sys_clk) disable iff (reset)
      (setup && !pwrite && hit_instr && bus8_ff) |=>
        prdata_ff[7:0] == {$past(busy_ff), $past(ac_ff)};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read wrong");

  property p_step_late;
    @(posedge sys_clk) disable iff (reset)
      (step_pend_ff && cnt_ff == CW'(1) && inc_ff && !instr_go) |=>
        ac_ff == $past(ac_ff) + 7'h01 && !busy_ff;
  endproperty
  a_step_late: assert property (p_step_late)
    else $error("address step not applied as busy fell");

  property p_display_data_ram_addr;
    @(posedge sys_clk) disable iff (reset)
      (instr_go && byte_in[7]) |=>
        ac_ff == $past(byte_in[6:0]) && ram_sel_ff == cdid_pkg::RAM_DISPLAY;
  endproperty
  a_display_data_ram_addr: assert property (p_display_data_ram_addr)
    else $error("display address not loaded");

  property p_font_table;
    @(posedge sys_clk) disable iff (reset)
      ft_ff != cdid_pkg::FONT_TABLE_NA;
  endproperty
  a_font_table: assert property (p_font_table)
    else $error("unavailable font table selected");

endmodule

// *** verif/cdid_host.sv ***
// Purpose: host processor model issuing apb transfers to the decoder
// Assumes: one transfer at a time, entered just after a rising edge
// Notes: released address and data show the inverse of the last value

`timescale 1ns/1ns

module cdid_host (
  input wire logic sys_clk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);

  // bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // one transfer; request held until pready is sampled high
  // hold keeps the bus so the next setup follows at once
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic hold,
                      output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // wait for the answer; only the bench watchdog ends a dead wait
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    if (!hold) begin
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
      // one idle edge, so no signal is assigned twice in a step
      @(posedge sys_clk);
    end
  endtask

  // poll the status word until the busy bit clears
  task automatic wait_idle();
    logic [31:0] s;
    logic e;
    do begin
      xfer(1'b0, 8'h08, 32'h0, 1'b0, s, e);
    end while (s[0] !== 1'b0);
  endtask

  // byte as two 4-bit transfers on bits 7:4, upper half first
  task automatic wr4(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, {24'h0, d[7:4], 4'h0}, 1'b0, r, e);
    wait_idle();
    xfer(1'b1, a, {24'h0, d[3:0], 4'h0}, 1'b0, r, e);
    wait_idle();
  endtask

  // byte read back as two nibbles, upper half first
  task automatic rd4(input logic [7:0] a, output logic [7:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, 32'h0, 1'b0, r, e);
    d[7:4] = r[7:4];
    wait_idle();
    xfer(1'b0, a, 32'h0, 1'b0, r, e);
    d[3:0] = r[7:4];
    wait_idle();
  endtask

endmodule

// *** verif/char_display_instruction_decoder_test.sv ***
// Purpose: self-checking bench of the display instruction decoder
// Assumes: host model drives apb, clear shortened to 20 cycles
// Notes: expected values come from the instruction encodings

`timescale 1ns/1ns

module char_display_instruction_decoder_test;

  localparam int unsigned CLR = 20; // shortened clear time
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, busy_flag;
  logic display_on, cursor_on, blink_on, graphic_mode, dcdc_on;
  logic bus_width_select, two_line, font_tall;
  logic [1:0] font_table;
  logic [6:0] display_shift;
  logic [7:0] paddr, b;
  logic [31:0] pwdata, prdata, r;
  logic e;
  int fail_count = 0;
  int n_checks = 0;

  cdid_top #(.CLEAR_CYC(CLR), .SHORT_CYC(2)) cdid_top_inst (
    .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .busy_flag(busy_flag),
    .display_on(display_on), .cursor_on(cursor_on),
    .blink_on(blink_on), .graphic_mode(graphic_mode),
    .dcdc_on(dcdc_on), .bus_width_select(bus_width_select),
    .two_line(two_line), .font_tall(font_tall),
    .font_table(font_table), .display_shift(display_shift));

  cdid_host cdid_host_inst (
    .sys_clk(sys_clk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  // single compare; four-state equality so x never matches
  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      fail_count++;
      $display("wrong value %s exp %h got %h", nm, ex, got);
    end
  endtask

  // short bus helpers
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic h);
    cdid_host_inst.xfer(1'b1, a, {24'h0, d}, h, r, e);
  endtask
  task automatic rd(input logic [7:0] a);
    cdid_host_inst.xfer(1'b0, a, 32'h0, 1'b0, r, e);
  endtask
  task automatic ins(input logic [7:0] c);
    wr(8'h00, c, 1'b0);
    cdid_host_inst.wait_idle();
  endtask

  task automatic t_reset();
    rd(8'h08);
    chk("status", 32'h0000_0208, r);
    chk("font_table", 32'h0, {30'h0, font_table});
    $display("test reset done");
  endtask

  // second instruction lands while busy and must be dropped
  task automatic t_ctrl();
    wr(8'h00, 8'h0F, 1'b1);
    wr(8'h00, 8'h08, 1'b0);
    cdid_host_inst.wait_idle();
    chk("disp", 32'h7, {display_on, cursor_on, blink_on});
    ins(8'h0C);
    chk("disp", 32'h4, {display_on, cursor_on, blink_on});
    $display("test control done");
  endtask

  task automatic t_data();
    ins(8'h85);
    wr(8'h04, 8'h41, 1'b1);
    rd(8'h00); // step still owed while busy
    chk("bf_ac", 32'h85, r);
    cdid_host_inst.wait_idle();
    wr(8'h04, 8'h42, 1'b0);
    cdid_host_inst.wait_idle();
    rd(8'h00);
    chk("ac", 32'h07, r);
    ins(8'h85);
    rd(8'h04);
    chk("rd0", 32'h41, r);
    cdid_host_inst.wait_idle();
    rd(8'h04);
    chk("rd1", 32'h42, r);
    cdid_host_inst.wait_idle();
    ins(8'h04); // decrement, no shift
    ins(8'h80);
    wr(8'h04, 8'h33, 1'b0);
    cdid_host_inst.wait_idle();
    rd(8'h00);
    chk("wrap", 32'h7F, r);
    $display("test data done");
  endtask

  task automatic t_glyph();
    ins(8'h7F);
    rd(8'h00);
    chk("gaddr", 32'h3F, r);
    wr(8'h04, 8'h1F, 1'b0);
    cdid_host_inst.wait_idle();
    rd(8'h08);
    chk("ramsel", 32'h1, {31'h0, r[1]});
    ins(8'h80);
    ins(8'h7F);
    rd(8'h04);
    chk("glyph", 32'h1F, r);
    cdid_host_inst.wait_idle();
    $display("test glyph done");
  endtask

  task automatic t_shift();
    ins(8'h06);
    ins(8'h8A);
    ins(8'h14);
    ins(8'h14);
    ins(8'h10);
    rd(8'h00);
    chk("cursor", 32'h0B, r);
    ins(8'h1C);
    rd(8'h00);
    chk("ac_kept", 32'h0B, r);
    chk("dshift", 32'h01, {25'h0, display_shift});
    ins(8'h18);
    chk("dshift", 32'h00, {25'h0, display_shift});
    ins(8'h1F);
    chk("mode", 32'h3, {graphic_mode, dcdc_on});
    ins(8'h17);
    chk("mode", 32'h1, {graphic_mode, dcdc_on});
    ins(8'h07); // increment with auto-shift
    wr(8'h04, 8'h55, 1'b0);
    cdid_host_inst.wait_idle();
    chk("auto", 32'h7F, {25'h0, display_shift});
    rd(8'h04);
    cdid_host_inst.wait_idle();
    chk("auto_rd", 32'h7E, {25'h0, display_shift});
    $display("test shift done");
  endtask

  task automatic t_clear();
    ins(8'h05);
    wr(8'h00, 8'h01, 1'b1);
    rd(8'h00);
    chk("clr_bf", 32'h1, {31'h0, r[7]});
    repeat (16) @(posedge sys_clk);
    chk("clr_busy", 32'h1, {31'h0, busy_flag});
    repeat (2) @(posedge sys_clk);
    chk("clr_done", 32'h0, {31'h0, busy_flag});
    rd(8'h08);
    chk("clr_st", 32'h0, r[22:16]);
    chk("clr_mode", 32'h3, {30'h0, r[3:2]});
    rd(8'h04);
    chk("blank", 32'h20, r);
    cdid_host_inst.wait_idle();
    ins(8'h1C);
    ins(8'h85);
    ins(8'h02);
    rd(8'h00);
    chk("home", 32'h00, r);
    chk("home_sh", 32'h0, {25'h0, display_shift});
    $display("test clear done");
  endtask

  task automatic t_func();
    ins(8'h3D);
    chk("func", 32'h1D, {bus_width_select, two_line, font_tall,
        font_table});
    ins(8'h33);
    chk("ft_na", 32'h1, {30'h0, font_table});
    ins(8'h26);
    chk("func4", 32'h06, {bus_width_select, two_line, font_tall,
        font_table});
    cdid_host_inst.wr4(8'h00, 8'h90);
    cdid_host_inst.wr4(8'h04, 8'h5A);
    cdid_host_inst.wr4(8'h00, 8'h90);
    cdid_host_inst.rd4(8'h04, b);
    chk("nib", 32'h5A, {24'h0, b});
    cdid_host_inst.wr4(8'h00, 8'h30);
    chk("bus8", 32'h1, {31'h0, bus_width_select});
    $display("test function done");
  endtask

  task automatic t_bus();
    rd(8'h0C);
    chk("unmapped", 32'h1, {31'h0, e});
    wr(8'h08, 8'h00, 1'b0);
    chk("st_wr", 32'h0, {31'h0, e});
    chk("disp", 32'h1, {31'h0, display_on});
    $display("test bus done");
  endtask

  // verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_ctrl();
    t_data();
    t_glyph();
    t_shift();
    t_clear();
    t_func();
    t_bus();
    conclude();
  end

  // the whole run needs well under 5000 cycles
  initial begin
    #200000;
    fail_count++;
    conclude();
  end

endmodule
